// ===== incdec_skip_or_branch_exec.sv
// Purpose: Executes increment/decrement-skip, increment, OR and absolute jump
// Assumes: Opcode, operands and latch come from logic on the same clock
// Notes:   File registers held in flip-flops; a preload port fills them
`timescale 1ns/100ps
`include "exec_defs.svh"
module incdec_skip_or_branch_exec #(
    parameter int FILE_DEPTH = 128
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic                 instValid,
    input  wire exec_pkg::op_t        instOp,
    input  wire logic [`FADDR_W-1:0]  fileAddr,
    input  wire logic                 destFile,
    input  wire logic [`JUMP_W-1:0]   immediate,
    input  wire logic [`DATA_W-1:0]   programCounterUpperLatch,
    input  wire logic                 loadEn,
    input  wire logic [`FADDR_W-1:0]  loadAddr,
    input  wire logic [`DATA_W-1:0]   loadData,
    input  wire logic [`FADDR_W-1:0]  peekAddr,
    output logic                      ready_ff,
    output logic                      retired_ff,
    output logic                      squashed_ff,
    output logic [`DATA_W-1:0]        accumulator_ff,
    output logic                      zeroFlag_ff,
    output logic [`PC_W-1:0]          programCounter_ff,
    output logic [`DATA_W-1:0]        peekData_ff
);
    import exec_pkg::*;

    logic [`DATA_W-1:0] fileMem_ff [FILE_DEPTH];
    exec_state_t        state_ff;

    alu_if aluBus ();
    exec_alu uAlu (
        .bus (aluBus)
    );

    // Instruction taken only in the execute state; flush cycle ignores the offered one
    wire take      = ce & instValid & (state_ff == ST_EXEC);
    wire isJump    = instOp == OP_ABSOLUTE_JUMP;
    wire [`DATA_W-1:0] fileRd = fileMem_ff[fileAddr];

    assign aluBus.op      = instOp;
    assign aluBus.fileVal = fileRd;
    assign aluBus.accVal  = accumulator_ff;
    assign aluBus.literal = immediate[`DATA_W-1:0];

    wire writeFile = take & aluBus.usesDest & destFile;
    wire writeAcc  = take & ((aluBus.usesDest & ~destFile)
                     | (instOp == OP_OR_LITERAL_TO_ACCUMULATOR));
    wire needFlush = take & (aluBus.skip | isJump);

    wire [`PC_W-1:0] jumpTarget = {programCounterUpperLatch[`LATCH_HI:`LATCH_LO], immediate};
    wire [`PC_W-1:0] pcInc      = programCounter_ff + `PC_W'(1);

    exec_state_t       nxt_state;
    wire [`PC_W-1:0]   nxt_pc = (take & isJump) ? jumpTarget :
                                (take | state_ff == ST_FLUSH) ? pcInc : programCounter_ff;

    // Jump and taken skip both spend one flush cycle on a discarded fetch
    always_comb begin
        case (state_ff)
            ST_EXEC:  nxt_state = needFlush ? ST_FLUSH : ST_EXEC;
            ST_FLUSH: nxt_state = ST_EXEC;
            default:  nxt_state = ST_EXEC;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff          <= ST_EXEC;
            ready_ff          <= 1'b1;
            retired_ff        <= 1'b0;
            squashed_ff       <= 1'b0;
            programCounter_ff <= `PC_RST;
        end else if (ce) begin
            state_ff          <= nxt_state;
            ready_ff          <= ~needFlush;
            retired_ff        <= take;
            squashed_ff       <= state_ff == ST_FLUSH;
            programCounter_ff <= nxt_pc;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_ff <= `ACC_RST;
            zeroFlag_ff    <= 1'b0;
        end else if (ce) begin
            if (writeAcc) begin
                accumulator_ff <= aluBus.result;
            end
            if (take & aluBus.setsZero) begin
                zeroFlag_ff <= aluBus.resultZero;
            end
        end
    end

    // Execution write wins over a preload to the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                fileMem_ff[i] <= `FILE_RST;
            end
            peekData_ff <= `FILE_RST;
        end else if (ce) begin
            if (writeFile) begin
                fileMem_ff[fileAddr] <= aluBus.result;
            end else if (loadEn) begin
                fileMem_ff[loadAddr] <= loadData;
            end
            peekData_ff <= fileMem_ff[peekAddr];
        end
    end
endmodule

// ===== exec_defs.svh
// Purpose: Constants for the increment, decrement, OR and jump execution block
// Assumes: One core clock, one instruction offered per cycle at most
// Notes:   Timing counts are in instruction cycles
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define DATA_W          8
`define FADDR_W         7
`define JUMP_W          11
`define PC_W            13
`define LATCH_LO        3
`define LATCH_HI        4
`define ACC_RST         8'h00
`define PC_RST          13'h0000
`define FILE_RST        8'h00
`define ONE_BYTE        8'h01
`define SQUASH_CYCLES   1

`endif

// ===== exec_pkg.sv
// Purpose: Types shared by the execution block and its datapath
// Assumes: Opcodes already decoded upstream
// Notes:   Codes are internal, not instruction word encodings
package exec_pkg;

    typedef enum logic [2:0] {
        OP_NOP                       = 3'h0,
        OP_DECREMENT_SKIP_ZERO       = 3'h1,
        OP_INCREMENT_SKIP_ZERO       = 3'h2,
        OP_INCREMENT_FILE            = 3'h3,
        OP_OR_LITERAL_TO_ACCUMULATOR = 3'h4,
        OP_OR_ACCUMULATOR_WITH_FILE  = 3'h5,
        OP_ABSOLUTE_JUMP             = 3'h6
    } op_t;

    typedef enum logic [0:0] {
        ST_EXEC  = 1'h0,
        ST_FLUSH = 1'h1
    } exec_state_t;

endpackage

// ===== alu_if.sv
// Purpose: Carrier between the sequencer and its datapath
// Assumes: Purely combinational datapath
// Notes:   None
`timescale 1ns/100ps
`include "exec_defs.svh"
interface alu_if;
    import exec_pkg::*;
    op_t                   op;
    logic [`DATA_W-1:0]    fileVal;
    logic [`DATA_W-1:0]    accVal;
    logic [`DATA_W-1:0]    literal;
    logic [`DATA_W-1:0]    result;
    logic                  resultZero;
    logic                  skip;
    logic                  setsZero;
    logic                  usesDest;

    modport seq (output op, fileVal, accVal, literal, input result, resultZero, skip, setsZero, usesDest);
    modport dp  (input op, fileVal, accVal, literal, output result, resultZero, skip, setsZero, usesDest);
endinterface

// ===== exec_alu.sv
// Purpose: Result, zero test and skip decision for one instruction
// Assumes: Operands stable for the cycle
// Notes:   No state; the sequencer registers everything
`timescale 1ns/100ps
`include "exec_defs.svh"
module exec_alu (
    alu_if.dp   bus
);
    import exec_pkg::*;

    function automatic logic [`DATA_W-1:0] step8(input logic [`DATA_W-1:0] v, input logic up);
        step8 = up ? v + `ONE_BYTE : v - `ONE_BYTE;
    endfunction

    wire isDecSkip = bus.op == OP_DECREMENT_SKIP_ZERO;
    wire isIncSkip = bus.op == OP_INCREMENT_SKIP_ZERO;
    wire isInc     = bus.op == OP_INCREMENT_FILE;
    wire isOrLit   = bus.op == OP_OR_LITERAL_TO_ACCUMULATOR;
    wire isOrFile  = bus.op == OP_OR_ACCUMULATOR_WITH_FILE;

    wire [`DATA_W-1:0] decVal = step8(bus.fileVal, 1'b0);
    wire [`DATA_W-1:0] incVal = step8(bus.fileVal, 1'b1);
    wire [`DATA_W-1:0] orLit  = bus.accVal | bus.literal;
    wire [`DATA_W-1:0] orFile = bus.accVal | bus.fileVal;

    assign bus.result = isDecSkip ? decVal :
                        (isIncSkip | isInc) ? incVal :
                        isOrLit ? orLit :
                        isOrFile ? orFile : bus.accVal;
    assign bus.resultZero = bus.result == 8'h00;
    assign bus.skip       = (isDecSkip | isIncSkip) & bus.resultZero;
    // Skip forms leave the zero flag alone
    assign bus.setsZero   = isInc | isOrLit | isOrFile;
    assign bus.usesDest   = isDecSkip | isIncSkip | isInc | isOrFile;
endmodule

// ===== incdec_monitor.sv
// Purpose: Port-level timing and result checks for the execution block
// Assumes: ce stays high while a flush cycle is pending
// Notes:   File register results are judged by the bench through peek
`timescale 1ns/100ps
module exec_checker (
    input wire logic           clk,
    input wire logic           rst_n,
    input wire logic           ce,
    input wire logic           instValid,
    input wire exec_pkg::op_t  instOp,
    input wire logic           destFile,
    input wire logic [10:0]    immediate,
    input wire logic [7:0]     programCounterUpperLatch,
    input wire logic           ready_ff,
    input wire logic           retired_ff,
    input wire logic           squashed_ff,
    input wire logic [7:0]     accumulator_ff,
    input wire logic           zeroFlag_ff,
    input wire logic [12:0]    programCounter_ff
);
    import exec_pkg::*;
    wire       tk = ce && instValid && ready_ff;
    wire       sk = instOp == OP_DECREMENT_SKIP_ZERO || instOp == OP_INCREMENT_SKIP_ZERO;
    wire       jp = instOp == OP_ABSOLUTE_JUMP;
    wire [1:0] up = programCounterUpperLatch[4:3];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_jump_target: assert property (tk && jp |=> programCounter_ff == {$past(up), $past(immediate)})
        else $error("jump target wrong");
    a_jump_flush: assert property ((tk && jp ##1 ce) |-> !ready_ff ##1 (ready_ff && squashed_ff))
        else $error("jump flush missing");
    a_skip_flags: assert property (tk && sk |=> $stable(zeroFlag_ff))
        else $error("skip changed zero flag");
    a_skip_decide: assert property (tk && sk && !destFile |=> ready_ff == (accumulator_ff != 8'h00))
        else $error("skip decision wrong");
    a_flush_quiet: assert property (!ready_ff && ce |=> ready_ff && squashed_ff && !retired_ff && $stable(accumulator_ff))
        else $error("flush cycle not a no-op");
    a_or_literal: assert property (tk && instOp == OP_OR_LITERAL_TO_ACCUMULATOR |=>
        accumulator_ff == 8'($past(accumulator_ff) | $past(immediate))) else $error("literal OR wrong");
    a_zero_result: assert property (tk && !destFile && !sk && !jp && instOp != OP_NOP |=>
        zeroFlag_ff == (accumulator_ff == 8'h00)) else $error("zero flag wrong");
    a_one_cycle: assert property (tk && !sk && !jp |=> ready_ff && retired_ff &&
        programCounter_ff == $past(programCounter_ff) + 13'h0001) else $error("single cycle op stalled");
endmodule
bind incdec_skip_or_branch_exec exec_checker u_exec_checker (.clk, .rst_n, .ce, .instValid, .instOp, .destFile,
    .immediate, .programCounterUpperLatch, .ready_ff, .retired_ff, .squashed_ff, .accumulator_ff, .zeroFlag_ff,
    .programCounter_ff);

// ===== incdec_skip_or_branch_exec_bench.sv
// Purpose: Directed scenarios for increment, skip, OR and jump execution
// Assumes: Every op is followed by one idle or flush cycle
// Notes:   Back-to-back issue is left to the port checker
`timescale 1ns/100ps
module incdec_skip_or_branch_exec_bench;
    import exec_pkg::*;
    logic        clk = 0, rst_n = 0, instValid = 0, destFile = 0, loadEn = 0, rdy, rdyAfter, retired, squashed, zero;
    logic        ce = 1, retAfter;
    op_t         instOp = OP_NOP;
    logic [6:0]  fileAddr = 7'h00, loadAddr = 7'h00, peekAddr = 7'h00;
    logic [10:0] immediate = 11'h000;
    logic [7:0]  latch = 8'h00, loadData = 8'h00, acc, peek;
    logic [12:0] pc, pc0;
    int          mismatches = 0, total_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    incdec_skip_or_branch_exec u_incdec_skip_or_branch_exec (.clk, .rst_n, .ce, .instValid, .instOp, .fileAddr,
        .destFile, .immediate, .programCounterUpperLatch(latch), .loadEn, .loadAddr, .loadData, .peekAddr,
        .ready_ff(rdy), .retired_ff(retired), .squashed_ff(squashed), .accumulator_ff(acc), .zeroFlag_ff(zero),
        .programCounter_ff(pc), .peekData_ff(peek));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic load(logic [6:0] a, logic [7:0] v);
        loadEn = 1;
        loadAddr = a;
        loadData = v;
        @(posedge clk) #1;
    endtask
    // Second cycle idles so skip and jump flushes need no re-offer
    task automatic exec(op_t op, logic [6:0] a, logic d, logic [10:0] k);
        loadEn = 0;
        instValid = 1;
        {instOp, fileAddr, peekAddr, destFile, immediate, pc0} = {op, a, a, d, k, pc};
        @(posedge clk) #1;
        rdyAfter = rdy;
        retAfter = retired;
        instValid = 0;
        @(posedge clk) #1;
    endtask
    task automatic expect_state(logic [7:0] a, logic [7:0] f, logic z, logic [12:0] step, logic r);
        check("accumulator", acc, a);
        check("file", peek, f);
        check("zero", zero, z);
        check("pc step", pc - pc0, step);
        check("ready", rdyAfter, r);
        check("retired", retAfter, ce);
    endtask
    task automatic t_increment;
        load(7'h05, 8'hFF);
        exec(OP_INCREMENT_FILE, 7'h05, 1'b1, 11'h000);
        expect_state(8'h00, 8'h00, 1'b1, 13'h0001, 1'b1);
        exec(OP_INCREMENT_FILE, 7'h05, 1'b0, 11'h000);
        expect_state(8'h01, 8'h00, 1'b0, 13'h0001, 1'b1);
    endtask
    task automatic t_decrement_skip;
        load(7'h06, 8'h01);
        exec(OP_DECREMENT_SKIP_ZERO, 7'h06, 1'b0, 11'h000);
        expect_state(8'h00, 8'h01, 1'b0, 13'h0002, 1'b0);
        check("skip squashed", squashed, 1'b1);
        load(7'h07, 8'h00);
        exec(OP_DECREMENT_SKIP_ZERO, 7'h07, 1'b1, 11'h000);
        expect_state(8'h00, 8'hFF, 1'b0, 13'h0001, 1'b1);
    endtask
    task automatic t_increment_skip;
        load(7'h08, 8'hFF);
        exec(OP_INCREMENT_SKIP_ZERO, 7'h08, 1'b1, 11'h000);
        expect_state(8'h00, 8'h00, 1'b0, 13'h0002, 1'b0);
        exec(OP_INCREMENT_SKIP_ZERO, 7'h08, 1'b0, 11'h000);
        expect_state(8'h01, 8'h00, 1'b0, 13'h0001, 1'b1);
    endtask
    task automatic t_or_ops;
        exec(OP_OR_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 11'h7A4);
        expect_state(8'hA5, 8'h00, 1'b0, 13'h0001, 1'b1);
        load(7'h09, 8'h5A);
        exec(OP_OR_ACCUMULATOR_WITH_FILE, 7'h09, 1'b1, 11'h000);
        expect_state(8'hA5, 8'hFF, 1'b0, 13'h0001, 1'b1);
    endtask
    task automatic t_jump;
        latch = 8'hEF;
        exec(OP_ABSOLUTE_JUMP, 7'h00, 1'b0, 11'h7FF);
        check("jump pc", pc, 13'h1000);
        check("jump ready", rdyAfter, 1'b0);
        check("jump squashed", squashed, 1'b1);
    endtask
    // Clock enable low must freeze every piece of state
    task automatic t_hold;
        ce = 0;
        exec(OP_INCREMENT_FILE, 7'h05, 1'b0, 11'h000);
        expect_state(8'hA5, 8'h00, 1'b0, 13'h0000, 1'b1);
        check("hold squashed", squashed, 1'b1);
        ce = 1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 500) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        t_increment();
        t_decrement_skip();
        t_increment_skip();
        t_or_ops();
        t_jump();
        t_hold();
        wrap_up();
    end
endmodule
